// ---- hw/fan_pkg.sv ----
// Shared constants and types for the fan drive acoustic ramp block
package fan_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADR_W  = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 8;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL  = 8'h40;
  localparam logic [7:0] IDX_DUTY1 = 8'h41;
  localparam logic [7:0] IDX_DUTY2 = 8'h42;
  localparam logic [7:0] IDX_DUTY3 = 8'h43;
  localparam logic [7:0] IDX_CFG1  = 8'h62;
  localparam logic [7:0] IDX_CFG2  = 8'h63;
  localparam logic [7:0] IDX_MDUTY1 = 8'h64;
  localparam logic [7:0] IDX_MDUTY2 = 8'h65;
  localparam logic [7:0] IDX_MDUTY3 = 8'h66;

  // ==========================================================
  // Field positions
  localparam int CFG1_RAMP_LSB = 0;
  localparam int CFG1_EN_BIT   = 3;
  localparam int CFG1_SYNC_BIT = 4;
  localparam int CFG1_FLR1_BIT = 5;
  localparam int CFG1_FLR2_BIT = 6;
  localparam int CFG1_FLR3_BIT = 7;
  localparam int CFG2_RAMP3_LSB = 0;
  localparam int CFG2_EN3_BIT   = 3;
  localparam int CFG2_RAMP2_LSB = 4;
  localparam int CFG2_EN2_BIT   = 7;
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_RAMP_LSB = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CFG1_RST     = 8'h00;
  localparam logic [7:0] CFG2_RST     = 8'h00;
  localparam logic [7:0] MIN_DUTY_RST = 8'h80;
  localparam logic [7:0] DUTY_OFF     = 8'h00;

  // ==========================================================
  // Timing: one slot is 1/171 of the 33% to 100% sweep at one count per slot
  localparam int SWEEP_MS    = 35000;
  localparam int SWEEP_STEPS = 171;
  localparam int CLK_KHZ     = 100000;
  localparam int SLOT_CYCLES_DFLT =
    int'((64'(SWEEP_MS) * 64'(CLK_KHZ)) / 64'(SWEEP_STEPS));
  localparam int SLOT_CNT_W = 25;

  typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} ramp_dir_e;

  // Duty counts moved per slot for each ramp code
  function automatic logic [7:0] ramp_step(input logic [2:0] code);
    case (code)
      3'h0:    ramp_step = 8'h01;
      3'h1:    ramp_step = 8'h02;
      3'h2:    ramp_step = 8'h03;
      3'h3:    ramp_step = 8'h05;
      3'h4:    ramp_step = 8'h08;
      3'h5:    ramp_step = 8'h0C;
      3'h6:    ramp_step = 8'h18;
      default: ramp_step = 8'h30;
    endcase
  endfunction

endpackage

// ---- hw/duty_ramp.sv ----
// Duty ramp unit: steps a duty value toward its target once per slot
`timescale 1ns/100ps
module duty_ramp
  import fan_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       slot_tick,
  input  wire logic       ramp_on,
  input  wire logic [2:0] ramp_code,
  input  wire logic [7:0] target,
  output logic      [7:0] duty,
  output logic            ramping
);

  typedef struct packed {
    logic [7:0] duty;
    ramp_dir_e  dir;
  } ramp_s;

  localparam ramp_s Q_RST = '{duty: DUTY_OFF, dir: RAMP_IDLE};

  ramp_s      q_r;
  ramp_s      q_nxt;
  logic [7:0] step;

  always_comb begin
    q_nxt = q_r;
    step  = ramp_step(ramp_code);
    if (!ramp_on) begin
      q_nxt.duty = target;
      q_nxt.dir  = RAMP_IDLE;
    end else if (target > q_r.duty) begin
      q_nxt.dir = RAMP_UP;
      if (slot_tick) begin
        q_nxt.duty = (target - q_r.duty <= step) ? target
                                                : q_r.duty + step;
      end
    end else if (target < q_r.duty) begin
      q_nxt.dir = RAMP_DOWN;
      if (slot_tick) begin
        q_nxt.duty = (q_r.duty - target <= step) ? target
                                                : q_r.duty - step;
      end
    end else begin
      q_nxt.dir = RAMP_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= Q_RST;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  assign duty    = q_r.duty;
  assign ramping = (q_r.dir != RAMP_IDLE);

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_direct_follow: assert property (
    clk_en && !ramp_on |=> duty == $past(target))
    else $error("duty did not follow target with ramp off");
  a_hold_between_slots: assert property (
    clk_en && ramp_on && !slot_tick |=> $stable(duty))
    else $error("duty moved outside a slot while ramping");
  a_step_size_up: assert property (
    clk_en && ramp_on && slot_tick && target > duty
      && (target - duty) > step
    |=> duty == $past(duty) + $past(step))
    else $error("ramp up step differs from rate code");
  a_no_overshoot: assert property (
    clk_en && ramp_on && slot_tick && target > duty
      && (target - duty) <= step
    |=> duty == $past(target))
    else $error("ramp overshoot or undershoot at target");

  c_ramp_up: cover property (clk_en && slot_tick && q_r.dir == RAMP_UP);
  c_ramp_down: cover property (
    clk_en && slot_tick && q_r.dir == RAMP_DOWN);

endmodule

// ---- hw/fan_drive_acoustic_ramp_config.sv ----
// Fan drive outputs with acoustic ramp, floor select and tach sync
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
// ============================================================
// Overview of operation
// - Output 1 ramps when its enable is set
// - Sync set: speed inputs 2-4 gated by out3
// - Sync clear: only speed inputs 3,4 gated
// - Auto below floor: out1 zero or minimum
// - Auto below floor: out2 zero or minimum
// - Auto below floor: out3 zero or minimum
// - Lock set: acoustic register writes ignored
// - Out3 ramps gradually at its selected rate
// - Ramp codes give 1,2,3,5,8,12,24,48 counts
// - Second acoustic register resets to zero
// - Minimum duty registers reset to half duty
module fan_drive_acoustic_ramp_config
  import fan_pkg::*;
#(
  parameter int SLOT_CYCLES = fan_pkg::SLOT_CYCLES_DFLT
) (
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic                      clk_en,
  input  wire logic                      wb_cyc,
  input  wire logic                      wb_stb,
  input  wire logic                      wb_we,
  input  wire logic [fan_pkg::ADR_W-1:0]  wb_adr,
  input  wire logic [3:0]                wb_sel,
  input  wire logic [fan_pkg::DATA_W-1:0] wb_dat_w,
  output logic      [fan_pkg::DATA_W-1:0] wb_dat_r,
  output logic                           wb_ack,
  input  wire logic [7:0]                calc_duty_1,
  input  wire logic [7:0]                calc_duty_2,
  input  wire logic [7:0]                calc_duty_3,
  input  wire logic                      below_floor_1,
  input  wire logic                      below_floor_2,
  input  wire logic                      below_floor_3,
  input  wire logic                      fan_speed_in_2,
  input  wire logic                      fan_speed_in_3,
  input  wire logic                      fan_speed_in_4,
  output logic                           fan_drive_out_1,
  output logic                           fan_drive_out_2,
  output logic                           fan_drive_out_3,
  output logic                           fan_speed_meas_2,
  output logic                           fan_speed_meas_3,
  output logic                           fan_speed_meas_4
);

  import fan_pkg::*;

  // ==========================================================
  // State
  // Bus answer and read data are part of the state, so the bus
  // outputs come from flip-flops like the rest.
  typedef struct packed {
    logic [7:0]            cfg1;
    logic [7:0]            cfg2;
    logic [2:0][7:0]       min_duty;
    logic                  lock;
    logic                  auto_mode;
    logic                  ack;
    logic [7:0]            rdata;
    logic [SLOT_CNT_W-1:0] slot_cnt;
    logic                  slot_tick;
    logic [7:0]            pwm_cnt;
    logic [2:0]            drive;
    logic [2:0]            speed_meas;
  } top_s;

  localparam top_s Q_RST = '{
    cfg1:     CFG1_RST,
    cfg2:     CFG2_RST,
    min_duty: {3{MIN_DUTY_RST}},
    default:  '0
  };

  localparam logic [SLOT_CNT_W-1:0] SLOT_LAST =
    SLOT_CNT_W'(SLOT_CYCLES - 1);

  top_s             q_r;
  top_s             q_nxt;
  logic [2:0][7:0]  target;
  logic [2:0][7:0]  duty;
  logic [2:0]       ramp_on;
  logic [2:0][2:0]  ramp_code;
  logic [2:0]       ramping;
  logic [IDX_W-1:0] idx;
  logic             req;
  logic             wr;
  logic             sync_all;

  // ==========================================================
  // Duty target selection
  // Below the floor in automatic mode the loop output is overridden,
  // either to off or to the programmed minimum.
  function automatic logic [7:0] floor_target(
    input logic       auto_on,
    input logic       below,
    input logic       use_min,
    input logic [7:0] min_val,
    input logic [7:0] calc
  );
    if (auto_on && below) begin
      floor_target = use_min ? min_val : DUTY_OFF;
    end else begin
      floor_target = calc;
    end
  endfunction

  always_comb begin
    target[0] = floor_target(q_r.auto_mode, below_floor_1,
      q_r.cfg1[CFG1_FLR1_BIT], q_r.min_duty[0], calc_duty_1);
    target[1] = floor_target(q_r.auto_mode, below_floor_2,
      q_r.cfg1[CFG1_FLR2_BIT], q_r.min_duty[1], calc_duty_2);
    target[2] = floor_target(q_r.auto_mode, below_floor_3,
      q_r.cfg1[CFG1_FLR3_BIT], q_r.min_duty[2], calc_duty_3);
  end

  // ==========================================================
  // Ramp units, one per drive output
  // All three outputs share one step table and one slot timer,
  // which keeps fans on a common supply stepping in lockstep.
  assign ramp_on[0]   = q_r.cfg1[CFG1_EN_BIT];
  assign ramp_on[1]   = q_r.cfg2[CFG2_EN2_BIT];
  assign ramp_on[2]   = q_r.cfg2[CFG2_EN3_BIT];
  assign ramp_code[0] = q_r.cfg1[CFG1_RAMP_LSB +: 3];
  assign ramp_code[1] = q_r.cfg2[CFG2_RAMP2_LSB +: 3];
  assign ramp_code[2] = q_r.cfg2[CFG2_RAMP3_LSB +: 3];

  for (genvar g = 0; g < 3; g++) begin : g_ramp
    duty_ramp u_ramp (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .clk_en    (clk_en),
      .slot_tick (q_r.slot_tick),
      .ramp_on   (ramp_on[g]),
      .ramp_code (ramp_code[g]),
      .target    (target[g]),
      .duty      (duty[g]),
      .ramping   (ramping[g])
    );
  end

  // ==========================================================
  // Register bus decode
  assign idx      = wb_adr[ADR_W-1:2];
  assign req      = wb_cyc && wb_stb && !q_r.ack;
  assign wr       = req && wb_we && wb_sel[0];
  assign sync_all = q_r.cfg1[CFG1_SYNC_BIT];

  always_comb begin
    q_nxt = q_r;

    // Slot timer paces every ramp step
    // Slot length is a parameter so that simulation can shorten
    // the 35 s sweep to a few thousand cycles.
    q_nxt.slot_tick = 1'b0;
    if (q_r.slot_cnt == SLOT_LAST) begin
      q_nxt.slot_cnt  = '0;
      q_nxt.slot_tick = 1'b1;
    end else begin
      q_nxt.slot_cnt = q_r.slot_cnt + SLOT_CNT_W'(1);
    end

    // Free running pulse width generator
    // Duty 0xFF still leaves one low count in every 256, so a
    // fan at full duty sees a short gap each period.
    q_nxt.pwm_cnt = q_r.pwm_cnt + 8'h01;
    for (int i = 0; i < 3; i++) begin
      q_nxt.drive[i] = (q_r.pwm_cnt < duty[i]);
    end

    // Speed samples 3,4 only taken while out3 drives (sample 2 too when sync is set), since a fan on a
    // switched supply gives no valid tach pulses in its off phase
    if (!sync_all || q_r.drive[2]) begin
      q_nxt.speed_meas[0] = fan_speed_in_2;
    end
    if (q_r.drive[2]) begin
      q_nxt.speed_meas[1] = fan_speed_in_3;
      q_nxt.speed_meas[2] = fan_speed_in_4;
    end

    // Single cycle answer to every request, mapped or not
    // Unmapped indices answer too, so a stray access never hangs
    // the master; reads give zero and writes are dropped.
    q_nxt.ack = req;
    if (req) begin
      case (idx)
        IDX_CTRL:  q_nxt.rdata = {3'h0, ramping, q_r.auto_mode,
                                  q_r.lock};
        IDX_DUTY1: q_nxt.rdata = duty[0];
        IDX_DUTY2: q_nxt.rdata = duty[1];
        IDX_DUTY3: q_nxt.rdata = duty[2];
        IDX_CFG1:  q_nxt.rdata = q_r.cfg1;
        IDX_CFG2:  q_nxt.rdata = q_r.cfg2;
        IDX_MDUTY1: q_nxt.rdata = q_r.min_duty[0];
        IDX_MDUTY2: q_nxt.rdata = q_r.min_duty[1];
        IDX_MDUTY3: q_nxt.rdata = q_r.min_duty[2];
        default:   q_nxt.rdata = 8'h00;
      endcase
    end

    // Byte lane 0 carries every register; other lanes are ignored
    if (wr) begin
      case (idx)
        IDX_CTRL: begin
          // Lock can only be set; reset is the only way out
          q_nxt.lock      = q_r.lock | wb_dat_w[CTRL_LOCK_BIT];
          q_nxt.auto_mode = wb_dat_w[CTRL_AUTO_BIT];
        end
        IDX_CFG1: begin
          if (!q_r.lock) begin
            q_nxt.cfg1 = wb_dat_w[7:0];
          end
        end
        IDX_CFG2: begin
          if (!q_r.lock) begin
            q_nxt.cfg2 = wb_dat_w[7:0];
          end
        end
        // Minimum duties stay writable under lock, so the floor can
        // still be tuned on a locked system.
        IDX_MDUTY1: q_nxt.min_duty[0] = wb_dat_w[7:0];
        IDX_MDUTY2: q_nxt.min_duty[1] = wb_dat_w[7:0];
        IDX_MDUTY3: q_nxt.min_duty[2] = wb_dat_w[7:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= Q_RST;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  assign wb_ack           = q_r.ack;
  assign wb_dat_r         = {24'h000000, q_r.rdata};
  assign fan_drive_out_1  = q_r.drive[0];
  assign fan_drive_out_2  = q_r.drive[1];
  assign fan_drive_out_3  = q_r.drive[2];
  assign fan_speed_meas_2 = q_r.speed_meas[0];
  assign fan_speed_meas_3 = q_r.speed_meas[1];
  assign fan_speed_meas_4 = q_r.speed_meas[2];

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_ack_single: assert property (
    clk_en && wb_ack |=> !wb_ack)
    else $error("ack held for more than one cycle");
  a_lock_cfg2_write: assert property (
    clk_en && q_r.lock && wr && idx == IDX_CFG2 |=> $stable(q_r.cfg2))
    else $error("write to locked acoustic register took effect");
  a_lock_cfg1_write: assert property (
    clk_en && q_r.lock && wr && idx == IDX_CFG1 |=> $stable(q_r.cfg1))
    else $error("write to locked acoustic register took effect");
  a_lock_sticky: assert property (
    q_r.lock |=> q_r.lock)
    else $error("lock bit cleared without reset");
  a_sync_gated: assert property (
    clk_en && sync_all && !q_r.drive[2] |=> $stable(fan_speed_meas_2))
    else $error("speed input 2 sampled while out3 is off");
  a_nosync_follow: assert property (
    clk_en && !sync_all |=> fan_speed_meas_2 == $past(fan_speed_in_2))
    else $error("speed input 2 gated with sync clear");
  a_out34_gated: assert property (
    clk_en && !q_r.drive[2] |=> $stable(fan_speed_meas_3)
      && $stable(fan_speed_meas_4))
    else $error("speed inputs 3 or 4 sampled while out3 is off");
  a_floor1_pick: assert property (
    q_r.auto_mode && below_floor_1 |-> target[0] ==
      (q_r.cfg1[CFG1_FLR1_BIT] ? q_r.min_duty[0] : DUTY_OFF))
    else $error("out1 floor target wrong");
  a_floor2_pick: assert property (
    q_r.auto_mode && below_floor_2 |-> target[1] ==
      (q_r.cfg1[CFG1_FLR2_BIT] ? q_r.min_duty[1] : DUTY_OFF))
    else $error("out2 floor target wrong");
  a_floor3_pick: assert property (
    q_r.auto_mode && below_floor_3 |-> target[2] ==
      (q_r.cfg1[CFG1_FLR3_BIT] ? q_r.min_duty[2] : DUTY_OFF))
    else $error("out3 floor target wrong");
  a_reset_values: assert property (
    $rose(arst_n) |-> q_r.cfg2 == CFG2_RST
      && q_r.min_duty[0] == MIN_DUTY_RST)
    else $error("register value after reset wrong");
  a_slot_spacing: assert property (
    clk_en && q_r.slot_tick |=> !q_r.slot_tick)
    else $error("slot ticks back to back");

  // ==========================================================
  // Bus and register checks
  a_ack_latency: assert property (
    clk_en && req |=> wb_ack)
    else $error("request not answered in the next cycle");
  a_read_cfg2: assert property (
    clk_en && req && !wb_we && idx == IDX_CFG2
    |=> wb_dat_r[7:0] == $past(q_r.cfg2))
    else $error("second acoustic register read back wrong");
  a_lock_set: assert property (
    clk_en && wr && idx == IDX_CTRL && wb_dat_w[CTRL_LOCK_BIT]
    |=> q_r.lock)
    else $error("lock bit not set by write");
  a_cfg1_open: assert property (
    clk_en && !q_r.lock && wr && idx == IDX_CFG1
    |=> q_r.cfg1 == $past(wb_dat_w[7:0]))
    else $error("unlocked write to acoustic register lost");
  a_min_write: assert property (
    clk_en && wr && idx == IDX_MDUTY1
    |=> q_r.min_duty[0] == $past(wb_dat_w[7:0]))
    else $error("minimum duty write lost");
  a_reset_minduty: assert property (
    $rose(arst_n) |-> q_r.min_duty == {3{MIN_DUTY_RST}})
    else $error("minimum duty value after reset wrong");

  // ==========================================================
  // Drive and speed checks
  a_pass_calc1: assert property (
    !(q_r.auto_mode && below_floor_1) |-> target[0] == calc_duty_1)
    else $error("out1 target differs from loop duty");
  a_drive_fan_drive_out_1: assert property (
    clk_en |=> fan_drive_out_1 == ($past(q_r.pwm_cnt) < $past(duty[0])))
    else $error("out1 drive level does not match its duty");
  a_sync2_sample: assert property (
    clk_en && sync_all && q_r.drive[2]
    |=> fan_speed_meas_2 == $past(fan_speed_in_2))
    else $error("speed input 2 missed while out3 drives");
  a_meas_follow: assert property (
    clk_en && q_r.drive[2]
    |=> fan_speed_meas_3 == $past(fan_speed_in_3)
      && fan_speed_meas_4 == $past(fan_speed_in_4))
    else $error("speed inputs 3 or 4 missed while out3 drives");
  a_slot_tick_due: assert property (
    clk_en && q_r.slot_cnt == SLOT_LAST |=> q_r.slot_tick)
    else $error("slot tick missing at end of slot");

  c_locked_write: cover property (
    clk_en && q_r.lock && wr && idx == IDX_CFG2);
  c_floor_min: cover property (
    q_r.auto_mode && below_floor_3 && q_r.cfg1[CFG1_FLR3_BIT]);
  c_sync_gate: cover property (
    clk_en && sync_all && q_r.drive[2] && fan_speed_in_2);

endmodule

// ---- tb/fan_tach_model.sv ----
// Behavioural fans: three tach lines pulsing at distinct rates
`timescale 1ns/100ps
module fan_tach_model (
  input  wire logic core_clk,
  input  wire logic arst_n,
  output logic      fan_speed_in_2,
  output logic      fan_speed_in_3,
  output logic      fan_speed_in_4
);
  logic [7:0] tick_r;

  // ==========================================================
  // Tach pulse source
  // Distinct rates, so a gate that stalls one line cannot hide behind another
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_r <= 8'h00;
    end else begin
      tick_r <= tick_r + 8'h01;
    end
  end

  assign fan_speed_in_2 = tick_r[1];
  assign fan_speed_in_3 = tick_r[2];
  assign fan_speed_in_4 = tick_r[0] ^ tick_r[3];
endmodule

// ---- tb/fan_drive_acoustic_ramp_config_tb.sv ----
// Register-level bench for the fan drive acoustic ramp block
`timescale 1ns/100ps
module fan_drive_acoustic_ramp_config_tb;
  import fan_pkg::*;
  localparam int         SLOT         = 16;
  localparam logic [7:0] STEP_TBL [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                          8'h08, 8'h0C, 8'h18, 8'h30};
  localparam logic [7:0] MIN_SET  [3] = '{8'h80, 8'h30, 8'h60};
  logic              core_clk, arst_n, clk_en, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [ADR_W-1:0]  wb_adr;
  logic [3:0]        wb_sel;
  logic [DATA_W-1:0] wb_dat_w, wb_dat_r;
  logic [7:0]        calc_1, calc_2, calc_3, rd;
  logic              bf_1, bf_2, bf_3, sp_2, sp_3, sp_4;
  logic              out_1, out_2, out_3, ms_2, ms_3, ms_4;
  int                fails, checks_done, c2, c3, c4, hi, h2, h3;

  fan_drive_acoustic_ramp_config #(.SLOT_CYCLES(SLOT)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .calc_duty_1(calc_1), .calc_duty_2(calc_2),
    .calc_duty_3(calc_3), .below_floor_1(bf_1), .below_floor_2(bf_2),
    .below_floor_3(bf_3), .fan_speed_in_2(sp_2), .fan_speed_in_3(sp_3),
    .fan_speed_in_4(sp_4), .fan_drive_out_1(out_1),
    .fan_drive_out_2(out_2), .fan_drive_out_3(out_3),
    .fan_speed_meas_2(ms_2), .fan_speed_meas_3(ms_3),
    .fan_speed_meas_4(ms_4));

  fan_tach_model fans (.core_clk(core_clk), .arst_n(arst_n),
    .fan_speed_in_2(sp_2), .fan_speed_in_3(sp_3), .fan_speed_in_4(sp_4));

  always #5 core_clk = ~core_clk;

  // ==========================================================
  // Reporting
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task timeout;
    fails++;
    conclude();
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // Wishbone classic cycle; ack and data are taken at the same edge
  task automatic bus(input logic we, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge core_clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= {idx, 2'b00};
    wb_dat_w <= {24'h000000, d};
    wb_sel   <= 4'hF;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    q = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask

  task rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, rd);
    chk(rd, exp);
  endtask

  task set_in(input logic [7:0] v, input logic b);
    @(posedge core_clk);
    {calc_1, calc_2, calc_3} <= {v, v, v};
    {bf_1, bf_2, bf_3}       <= {b, b, b};
    repeat (4) @(posedge core_clk);
  endtask

  task automatic tach;
    logic [2:0] prev;
    c2 = 0;
    c3 = 0;
    c4 = 0;
    @(posedge core_clk);
    prev = {ms_2, ms_3, ms_4};
    repeat (64) begin
      @(posedge core_clk);
      c2 += int'(ms_2 !== prev[2]);
      c3 += int'(ms_3 !== prev[1]);
      c4 += int'(ms_4 !== prev[0]);
      prev = {ms_2, ms_3, ms_4};
    end
  endtask

  // ==========================================================
  // Ramp: first two slot steps from zero must equal the code's step
  task automatic ramp(input int n, input logic [2:0] code);
    logic [7:0] cidx, cval, didx, q;
    int         k;
    cidx = (n == 1) ? IDX_CFG1 : IDX_CFG2;
    cval = (n == 2) ? {1'b1, code, 4'h0} : {5'h01, code};
    didx = IDX_DUTY1 + 8'(n - 1);
    wr(cidx, 8'h00);
    set_in(8'h00, 1'b0);
    rdc(didx, 8'h00);
    wr(cidx, cval);
    set_in(8'hFF, 1'b0);
    q = 8'h00;
    for (k = 0; k < 40 && q === 8'h00; k++) bus(1'b0, didx, 8'h00, q);
    if (k >= 40) timeout();
    chk(q, STEP_TBL[code]);
    for (k = 0; k < 40 && q === STEP_TBL[code]; k++) begin
      bus(1'b0, didx, 8'h00, q);
    end
    if (k >= 40) timeout();
    chk(q, {STEP_TBL[code][6:0], 1'b0});
    wr(cidx, 8'h00);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {core_clk, arst_n, wb_cyc, wb_stb, wb_we} = 5'h00;
    clk_en   = 1'b1;
    wb_adr   = '0;
    wb_sel   = 4'h0;
    wb_dat_w = '0;
    {calc_1, calc_2, calc_3, bf_1, bf_2, bf_3} = '0;
    fails       = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rdc(IDX_CFG1, 8'h00);
    rdc(IDX_CFG2, 8'h00);
    for (int i = 0; i < 3; i++) rdc(IDX_MDUTY1 + 8'(i), 8'h80);
    rdc(8'h70, 8'h00);
    for (int i = 0; i < 8; i++) ramp(3, 3'(i));
    ramp(1, 3'h3);
    ramp(2, 3'h5);
    // Floor choice under automatic mode
    wr(IDX_CTRL, 8'h02);
    for (int i = 0; i < 3; i++) wr(IDX_MDUTY1 + 8'(i), MIN_SET[i]);
    wr(IDX_CFG1, 8'h00);
    set_in(8'hFF, 1'b1);
    for (int i = 0; i < 3; i++) rdc(IDX_DUTY1 + 8'(i), 8'h00);
    wr(IDX_CFG1, 8'hE0);
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 3; i++) rdc(IDX_DUTY1 + 8'(i), MIN_SET[i]);
    hi = 0;
    h2 = 0;
    h3 = 0;
    repeat (256) begin
      @(posedge core_clk);
      hi += int'(out_1 === 1'b1);
      h2 += int'(out_2 === 1'b1);
      h3 += int'(out_3 === 1'b1);
    end
    chk(8'(hi), 8'h80);
    chk(8'(h2), MIN_SET[1]);
    chk(8'(h3), MIN_SET[2]);
    set_in(8'hFF, 1'b0);
    rdc(IDX_DUTY1, 8'hFF);
    wr(IDX_CTRL, 8'h00);
    set_in(8'hFF, 1'b1);
    rdc(IDX_DUTY3, 8'hFF);
    // Tach gating, drive 3 held low then high
    set_in(8'h00, 1'b0);
    wr(IDX_CFG1, 8'h00);
    tach();
    chk(8'(c2 > 0), 8'h01);
    chk(8'(c3 > 0), 8'h00);
    wr(IDX_CFG1, 8'h10);
    tach();
    chk(8'(c2 > 0), 8'h00);
    chk(8'(c4 > 0), 8'h00);
    set_in(8'hFF, 1'b0);
    tach();
    chk(8'(c2 > 0), 8'h01);
    chk(8'(c4 > 0), 8'h01);
    // Lock freezes both acoustic registers, not the minimum duties
    wr(IDX_CTRL, 8'h01);
    wr(IDX_CFG1, 8'h55);
    rdc(IDX_CFG1, 8'h10);
    wr(IDX_CFG2, 8'hAA);
    rdc(IDX_CFG2, 8'h00);
    wr(IDX_MDUTY1, 8'h22);
    rdc(IDX_MDUTY1, 8'h22);
    wr(IDX_CTRL, 8'h00);
    rdc(IDX_CTRL, 8'h01);
    // Clock enable low must freeze the gated speed samples too
    clk_en <= 1'b0;
    tach();
    chk(8'(c2 + c4), 8'h00);
    clk_en <= 1'b1;
    conclude();
  end
endmodule
